/* audio_lane_model.sv */
// source and sink standing for the audio path around one lane
module audio_lane_model
#(
  parameter int W = 24
)
(
  input  wire logic                pclk,
  output logic                     in_valid,
  output logic signed [W-1:0]      in_data,
  input  wire logic                in_ready,
  input  wire logic                out_valid,
  input  wire logic signed [W-1:0] out_data,
  output logic                     out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [W-1:0] got[$];
  logic                stall = 1'b0;
  initial
  begin
    in_valid = 1'b0;
    in_data = '0;
    out_ready = 1'b0;
  end
  // ========
  // source: idle data inverted so stale words never look valid
  task automatic send(input logic signed [W-1:0] v, output bit ok);
    int n;
    bit done;
    n = 0;
    @(posedge pclk);
    in_valid <= 1'b1;
    in_data <= v;
    do
    begin
      @(posedge pclk);
      n++;
      done = in_ready === 1'b1;
    end
    while (!done && n < 50);
    in_valid <= 1'b0;
    in_data <= ~v;
    ok = done;
  endtask
  // ========
  // sink: stall is set by the bench only
  always @(posedge pclk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back(out_data);
    out_ready <= !stall;
  end
endmodule

/* codec_filters_pkg.sv */
// constants shared by the microphone filter and compressor block
// ============================================================
// Functional notes
// [RULE1] mic high-pass enable at bit 4, 1 enables, resets to 1.
// [RULE2] cut-off code bits 6:5, reset 00: hi-fi, voice 1, 2, 3.
// [RULE3] hi-fi mode removes dc, keeps bass, about 3.7 Hz at 44.1 kHz.
// [RULE4] every cut-off scales with sample rate, hi-fi 4 Hz at 48 kHz.
// [RULE5] software should pick voice cut-offs below 300 Hz.
// [RULE6] compressor runs only when bit 15 is 1; resets to 0.
// [RULE7] bit 14 routes compressor: 0 microphone path, 1 dac path.
// [RULE8] compressor never works on both paths at once.
// [RULE9] knee splits curve; upper slope above knee, lower slope below.
// [RULE10] slope 1 keeps gain, below 1 compresses, 0 fixes output level.
// [RULE11] knee input bits 10:5, 0.75 dB steps to -45 dB, above reserved.
// [RULE12] knee output bits 4:0, 0.75 dB steps to -22.5 dB, 31 reserved.
// [RULE13] upper slope bits 5:3: 1, 1/2, 1/4, 1/8, 1/16, 0; rest reserved.
// [RULE14] lower slope bits 2:0: 1, 1/2, 1/4, 1/8, 0; rest reserved.
// [RULE15] 0 dB input output is knee output minus knee input times slope.
// [RULE16] compressor disabled passes selected path unchanged, no delay.
// [RULE17] high-pass disabled passes microphone samples unchanged.
package codec_filters_pkg;
  // ============================================================
  // register map: printed offsets are word indices
  localparam logic [7:0] IDX_MIC_FILTER_CONFIG   = 8'h26;
  localparam logic [7:0] IDX_COMPRESSOR_CONTROL_A = 8'h28;
  localparam logic [7:0] IDX_COMPRESSOR_SLOPES   = 8'h2a;
  localparam logic [7:0] IDX_COMPRESSOR_KNEE     = 8'h2b;
  // ============================================================
  // field positions
  localparam int HPF_ENABLE_BIT   = 4;
  localparam int HPF_CUT_LSB      = 5;
  localparam int COMP_ENABLE_BIT  = 15;
  localparam int COMP_PATH_BIT    = 14;
  localparam int HI_SLOPE_LSB     = 3;
  localparam int LO_SLOPE_LSB     = 0;
  localparam int KNEE_IN_LSB      = 5;
  localparam int KNEE_OUT_LSB     = 0;
  // ============================================================
  // reset values
  localparam logic       HPF_ENABLE_RST  = 1'b1;
  localparam logic [1:0] HPF_CUT_RST     = 2'h0;
  localparam logic       COMP_ENABLE_RST = 1'b0;
  localparam logic       COMP_PATH_RST   = 1'b0;
  localparam logic [2:0] SLOPE_RST       = 3'h0;
  localparam logic [5:0] KNEE_IN_RST     = 6'h00;
  localparam logic [4:0] KNEE_OUT_RST    = 5'h00;
  // ============================================================
  // code limits
  localparam logic [5:0] KNEE_IN_MAX     = 6'h3c;
  localparam logic [4:0] KNEE_OUT_MAX    = 5'h1e;
  localparam logic [2:0] HI_SLOPE_ZERO   = 3'h5;
  localparam logic [2:0] LO_SLOPE_ZERO   = 3'h4;
  // ============================================================
  // filter pole shifts per cut-off code; fc tracks fs by construction
  localparam logic [3:0] HPF_SHIFT_HIFI   = 4'hb;
  localparam logic [3:0] HPF_SHIFT_VOICE1 = 4'h4;
  localparam logic [3:0] HPF_SHIFT_VOICE2 = 4'h3;
  localparam logic [3:0] HPF_SHIFT_VOICE3 = 4'h2;
  localparam int         HPF_FRAC_BITS    = 8;
  // gain steps of 0.75 dB: eight per 6 dB octave, mantissa in q7
  localparam int         GAIN_FRAC_BITS   = 7;
  localparam logic [7:0] GAIN_FRAC [8] = '{8'h80, 8'h8c, 8'h98, 8'ha6,
                                           8'hb5, 8'hc5, 8'hd7, 8'hea};
endpackage

/* hpf_comp_props.sv */
// assertions on the bus and stream ports of the filter block
module hpf_comp_props
#(
  parameter int SAMPLE_W = 24,
  parameter int ADDR_W   = 10
)
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [ADDR_W-1:0]          paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       mic_in_valid,
  input wire logic                       mic_in_ready,
  input wire logic                       mic_out_valid,
  input wire logic signed [SAMPLE_W-1:0] mic_out_data,
  input wire logic                       mic_out_ready,
  input wire logic                       dac_out_valid,
  input wire logic signed [SAMPLE_W-1:0] dac_out_data,
  input wire logic                       dac_out_ready
);
  logic mapped;
  assign mapped = paddr == 'h98 || paddr == 'ha0 || paddr == 'ha8
                  || paddr == 'hac;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // bus and stream steps
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence mic_take_s;
    mic_in_valid && mic_in_ready;
  endsequence
  AST_READY_AFTER_SETUP:
    assert property (setup_s |=> pready && penable)
    else $error("no ready after setup");
  AST_READY_ONLY_ACCESS:
    assert property (pready |-> psel && $past(psel && !penable))
    else $error("ready outside access");
  AST_ERR_UNMAPPED:
    assert property (setup_s ##0 !mapped |=> pslverr)
    else $error("unmapped address not refused");
  AST_NO_ERR_MAPPED:
    assert property (setup_s ##0 mapped |=> !pslverr)
    else $error("mapped address refused");
  AST_UPPER_ZERO:
    assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  AST_MIC_HOLD:
    assert property (mic_out_valid && !mic_out_ready
                     |=> mic_out_valid && $stable(mic_out_data))
    else $error("mic word dropped while stalled");
  AST_DAC_HOLD:
    assert property (dac_out_valid && !dac_out_ready
                     |=> dac_out_valid && $stable(dac_out_data))
    else $error("dac word dropped while stalled");
  AST_MIC_LATENCY:
    assert property (mic_take_s ##0 !mic_out_valid |=> mic_out_valid)
    else $error("mic word late");
  AST_FULL_ONLY_STALLED:
    assert property ($fell(mic_in_ready) |-> mic_out_valid
                     && $past(mic_in_valid) && !$past(mic_out_ready))
    else $error("input refused without stall");
endmodule

bind mic_hpf_and_compressor_curve hpf_comp_props #(
  .SAMPLE_W(SAMPLE_W),
  .ADDR_W  (ADDR_W)
) u_props (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .mic_in_valid, .mic_in_ready, .mic_out_valid, .mic_out_data,
  .mic_out_ready, .dac_out_valid, .dac_out_data, .dac_out_ready
);

/* mic_hpf_and_compressor_curve.sv */
// microphone high-pass filter and compressor static curve with apb access
//
// Design decision made here: the APB interface to the registers.
module mic_hpf_and_compressor_curve
#(
  parameter int SAMPLE_W = 24,
  parameter int ADDR_W   = 10
)
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       mic_in_valid,
  input  wire logic signed [SAMPLE_W-1:0] mic_in_data,
  output logic                            mic_in_ready,
  output logic                            mic_out_valid,
  output logic signed [SAMPLE_W-1:0]      mic_out_data,
  input  wire logic                       mic_out_ready,
  input  wire logic                       dac_in_valid,
  input  wire logic signed [SAMPLE_W-1:0] dac_in_data,
  output logic                            dac_in_ready,
  output logic                            dac_out_valid,
  output logic signed [SAMPLE_W-1:0]      dac_out_data,
  input  wire logic                       dac_out_ready
);

  localparam int HW = SAMPLE_W + 2 + codec_filters_pkg::HPF_FRAC_BITS;
  localparam int CW = 2 * SAMPLE_W + 16;
  localparam int LANES = 2;

  // ============================================================
  // register fields
  logic       mic_highpass_enable;
  logic [1:0] mic_highpass_cutoff_select;
  logic       compressor_enable;
  logic       compressor_path_select;
  logic [2:0] upper_region_slope;
  logic [2:0] lower_region_slope;
  logic [5:0] knee_input_level;
  logic [4:0] knee_output_level;

  // word index of an aligned address, or all ones when not one of ours
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = 8'hff;
    if (a[1:0] == 2'h0 && (a >> 2) < (ADDR_W)'(256))
    begin
      idx = 8'(a >> 2);
    end
    case (idx)
      codec_filters_pkg::IDX_MIC_FILTER_CONFIG,
      codec_filters_pkg::IDX_COMPRESSOR_CONTROL_A,
      codec_filters_pkg::IDX_COMPRESSOR_SLOPES,
      codec_filters_pkg::IDX_COMPRESSOR_KNEE: reg_index = idx;
      default: reg_index = 8'hff;
    endcase
  endfunction

  function automatic logic [15:0] byte_mask(input logic [3:0] s);
    byte_mask = {{8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  s);
    merge = (old & ~byte_mask(s)) | (wd[15:0] & byte_mask(s));
  endfunction

  logic [7:0]  acc_index;
  logic        write_now;
  logic [15:0] read_word;
  logic [15:0] w_filter;
  logic [15:0] w_ctrl;
  logic [15:0] w_slopes;
  logic [15:0] w_knee;

  assign acc_index = reg_index(paddr);
  assign write_now = psel & penable & pready & pwrite & ~pslverr;

  always_comb
  begin
    w_filter = '0;
    w_filter[codec_filters_pkg::HPF_ENABLE_BIT] = mic_highpass_enable;
    w_filter[codec_filters_pkg::HPF_CUT_LSB +: 2] =
      mic_highpass_cutoff_select;
    w_ctrl = '0;
    w_ctrl[codec_filters_pkg::COMP_ENABLE_BIT] = compressor_enable;
    w_ctrl[codec_filters_pkg::COMP_PATH_BIT] = compressor_path_select;
    w_slopes = '0;
    w_slopes[codec_filters_pkg::HI_SLOPE_LSB +: 3] = upper_region_slope;
    w_slopes[codec_filters_pkg::LO_SLOPE_LSB +: 3] = lower_region_slope;
    w_knee = '0;
    w_knee[codec_filters_pkg::KNEE_IN_LSB +: 6] = knee_input_level;
    w_knee[codec_filters_pkg::KNEE_OUT_LSB +: 5] = knee_output_level;
    case (acc_index)
      codec_filters_pkg::IDX_MIC_FILTER_CONFIG:    read_word = w_filter;
      codec_filters_pkg::IDX_COMPRESSOR_CONTROL_A: read_word = w_ctrl;
      codec_filters_pkg::IDX_COMPRESSOR_SLOPES:    read_word = w_slopes;
      codec_filters_pkg::IDX_COMPRESSOR_KNEE:      read_word = w_knee;
      default:                                     read_word = 16'h0000;
    endcase
  end

  // ============================================================
  // apb slave: one wait-free access phase, answer registered in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (acc_index == 8'hff);
      if (psel && !penable)
      begin
        prdata <= {16'h0000, read_word};
      end
    end
  end

  // [RULE1] [RULE2] [RULE17] filter enable and cut-off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mic_highpass_enable        <= codec_filters_pkg::HPF_ENABLE_RST;
      mic_highpass_cutoff_select <= codec_filters_pkg::HPF_CUT_RST;
    end
    else if (write_now &&
             acc_index == codec_filters_pkg::IDX_MIC_FILTER_CONFIG)
    begin
      mic_highpass_enable <= merge(w_filter, pwdata, pstrb)
                             [codec_filters_pkg::HPF_ENABLE_BIT];
      mic_highpass_cutoff_select <= merge(w_filter, pwdata, pstrb)
                                    [codec_filters_pkg::HPF_CUT_LSB +: 2];
    end
  end

  // [RULE6] [RULE7] compressor enable and path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compressor_enable      <= codec_filters_pkg::COMP_ENABLE_RST;
      compressor_path_select <= codec_filters_pkg::COMP_PATH_RST;
    end
    else if (write_now &&
             acc_index == codec_filters_pkg::IDX_COMPRESSOR_CONTROL_A)
    begin
      compressor_enable <= merge(w_ctrl, pwdata, pstrb)
                           [codec_filters_pkg::COMP_ENABLE_BIT];
      compressor_path_select <= merge(w_ctrl, pwdata, pstrb)
                                [codec_filters_pkg::COMP_PATH_BIT];
    end
  end

  // [RULE13] [RULE14] slope codes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_region_slope <= codec_filters_pkg::SLOPE_RST;
      lower_region_slope <= codec_filters_pkg::SLOPE_RST;
    end
    else if (write_now &&
             acc_index == codec_filters_pkg::IDX_COMPRESSOR_SLOPES)
    begin
      upper_region_slope <= merge(w_slopes, pwdata, pstrb)
                            [codec_filters_pkg::HI_SLOPE_LSB +: 3];
      lower_region_slope <= merge(w_slopes, pwdata, pstrb)
                            [codec_filters_pkg::LO_SLOPE_LSB +: 3];
    end
  end

  // [RULE11] [RULE12] knee levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      knee_input_level  <= codec_filters_pkg::KNEE_IN_RST;
      knee_output_level <= codec_filters_pkg::KNEE_OUT_RST;
    end
    else if (write_now &&
             acc_index == codec_filters_pkg::IDX_COMPRESSOR_KNEE)
    begin
      knee_input_level <= merge(w_knee, pwdata, pstrb)
                          [codec_filters_pkg::KNEE_IN_LSB +: 6];
      knee_output_level <= merge(w_knee, pwdata, pstrb)
                           [codec_filters_pkg::KNEE_OUT_LSB +: 5];
    end
  end

  // ============================================================
  // high-pass filter: y = x - x1 + y1 - y1/2^k, fractional guard bits
  logic signed [SAMPLE_W-1:0] hpf_x_prev;
  logic signed [HW-1:0]       hpf_y;
  logic signed [HW-1:0]       next_hpf_y;
  logic signed [SAMPLE_W-1:0] hpf_out;
  logic [3:0]                 hpf_shift;
  logic [LANES-1:0]           lane_push;

  // [RULE3] [RULE4] pole shift per cut-off code
  always_comb
  begin
    case (mic_highpass_cutoff_select)
      2'h0:    hpf_shift = codec_filters_pkg::HPF_SHIFT_HIFI;
      2'h1:    hpf_shift = codec_filters_pkg::HPF_SHIFT_VOICE1;
      2'h2:    hpf_shift = codec_filters_pkg::HPF_SHIFT_VOICE2;
      default: hpf_shift = codec_filters_pkg::HPF_SHIFT_VOICE3;
    endcase
  end

  function automatic logic signed [SAMPLE_W-1:0] sat(
    input logic signed [CW-1:0] v);
    logic signed [CW-1:0] hi;
    logic signed [CW-1:0] lo;
    hi = (CW)'({1'b0, {(SAMPLE_W-1){1'b1}}});
    lo = -hi - (CW)'(1);
    if (v > hi)
      sat = SAMPLE_W'(hi);
    else if (v < lo)
      sat = SAMPLE_W'(lo);
    else
      sat = SAMPLE_W'(v);
  endfunction

  always_comb
  begin
    next_hpf_y = ((HW'(mic_in_data) - HW'(hpf_x_prev))
                  <<< codec_filters_pkg::HPF_FRAC_BITS)
                 + hpf_y - (hpf_y >>> hpf_shift);
    // [RULE17] bypass leaves samples untouched
    if (mic_highpass_enable)
      hpf_out = sat(CW'(next_hpf_y >>> codec_filters_pkg::HPF_FRAC_BITS));
    else
      hpf_out = mic_in_data;
  end

  // state moves only on accepted samples; hpf_y cleared while bypassed, hpf_x_prev still loaded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hpf_x_prev <= '0;
      hpf_y      <= '0;
    end
    else if (lane_push[0])
    begin
      hpf_x_prev <= mic_in_data;
      hpf_y      <= mic_highpass_enable ? next_hpf_y : '0;
    end
  end

  // ============================================================
  // compressor static curve, levels in 0.75 dB attenuation steps
  logic signed [SAMPLE_W-1:0] comp_in;
  logic signed [SAMPLE_W-1:0] comp_out;
  logic [SAMPLE_W-1:0]        comp_mag;
  logic [SAMPLE_W-1:0]        comp_norm;
  logic signed [CW-1:0]       comp_prod;
  logic signed [CW-1:0]       comp_scaled;

  // [RULE10] slope codes as shifts; zero slope drops the difference
  function automatic int apply_slope(input int diff, input logic [2:0] c,
                                     input logic upper);
    if ((upper && c == codec_filters_pkg::HI_SLOPE_ZERO) ||
        (!upper && c == codec_filters_pkg::LO_SLOPE_ZERO))
      apply_slope = 0;
    else if (c > (upper ? codec_filters_pkg::HI_SLOPE_ZERO
                        : codec_filters_pkg::LO_SLOPE_ZERO))
      apply_slope = diff;
    else
      apply_slope = diff >>> c;
  endfunction

  // [RULE8] a single curve fed from the selected path only
  assign comp_in = compressor_path_select ? dac_in_data : hpf_out;

  always_comb
  begin
    int msb;
    int att;
    int k_in;
    int k_out;
    int out_att;
    int gain;
    int q;
    msb = -1;
    att = 0;
    k_in = 0;
    k_out = 0;
    out_att = 0;
    gain = 0;
    q = 0;
    comp_mag = comp_in[SAMPLE_W-1] ? SAMPLE_W'(-comp_in) : comp_in;
    for (int i = 0; i < SAMPLE_W; i++)
    begin
      if (comp_mag[i])
        msb = i;
    end
    comp_norm = comp_mag << (SAMPLE_W - 1 - msb);
    if (msb < 0)
      att = SAMPLE_W * 8;
    else
      att = (SAMPLE_W - 1 - msb) * 8 - 1 - int'(comp_norm[SAMPLE_W-2 -: 3]);
    if (att < 0)
      att = 0;
    // [RULE11] [RULE12] reserved knee codes hold at the deepest level
    k_in = (knee_input_level > codec_filters_pkg::KNEE_IN_MAX) ?
           int'(codec_filters_pkg::KNEE_IN_MAX) : int'(knee_input_level);
    k_out = (knee_output_level > codec_filters_pkg::KNEE_OUT_MAX) ?
            int'(codec_filters_pkg::KNEE_OUT_MAX) : int'(knee_output_level);
    // [RULE9] [RULE15] upper line meets 0 dB at knee_out - knee_in*slope
    if (att <= k_in)
      out_att = k_out - apply_slope(k_in - att, upper_region_slope, 1'b1);
    else
      out_att = k_out + apply_slope(att - k_in, lower_region_slope, 1'b0);
    gain = att - out_att;
    q = gain >>> 3;
    if (q > SAMPLE_W)
      q = SAMPLE_W;
    comp_prod = CW'(comp_in) *
                CW'({1'b0, codec_filters_pkg::GAIN_FRAC[gain & 7]});
    if (q >= 0)
      comp_scaled = (comp_prod <<< q) >>> codec_filters_pkg::GAIN_FRAC_BITS;
    else
      comp_scaled = comp_prod >>> (codec_filters_pkg::GAIN_FRAC_BITS - q);
    comp_out = sat(comp_scaled);
  end

  // ============================================================
  // lanes: 0 microphone, 1 dac; two-entry buffer on each
  logic [LANES-1:0]           lane_in_valid;
  logic [LANES-1:0]           lane_in_ready;
  logic [LANES-1:0]           lane_out_ready;
  logic [LANES-1:0]           head_valid;
  logic [LANES-1:0]           spare_valid;
  logic signed [SAMPLE_W-1:0] lane_data [LANES];
  logic signed [SAMPLE_W-1:0] head_data [LANES];
  logic signed [SAMPLE_W-1:0] spare_data [LANES];

  assign lane_in_valid  = {dac_in_valid, mic_in_valid};
  assign lane_out_ready = {dac_out_ready, mic_out_ready};

  // [RULE6] [RULE7] [RULE16] compressor only on the chosen lane
  always_comb
  begin
    lane_data[0] = (compressor_enable && !compressor_path_select) ?
                   comp_out : hpf_out;
    lane_data[1] = (compressor_enable && compressor_path_select) ?
                   comp_out : dac_in_data;
  end

  for (genvar g = 0; g < LANES; g++)
  begin : lane
    logic pop;
    logic next_spare_valid;
    assign lane_push[g] = lane_in_valid[g] & lane_in_ready[g];
    assign pop = head_valid[g] & lane_out_ready[g];
    assign next_spare_valid = spare_valid[g] ? ~pop
                              : (lane_push[g] & head_valid[g] & ~pop);

    // ready is registered, so a full buffer stalls the source
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        head_valid[g]    <= 1'b0;
        spare_valid[g]   <= 1'b0;
        lane_in_ready[g] <= 1'b0;
        head_data[g]     <= '0;
        spare_data[g]    <= '0;
      end
      else
      begin
        spare_valid[g]   <= next_spare_valid;
        lane_in_ready[g] <= ~next_spare_valid;
        if (spare_valid[g])
        begin
          if (pop)
            head_data[g] <= spare_data[g];
        end
        else if (lane_push[g])
        begin
          if (!head_valid[g] || pop)
          begin
            head_data[g]  <= lane_data[g];
            head_valid[g] <= 1'b1;
          end
          else
            spare_data[g] <= lane_data[g];
        end
        else if (pop)
          head_valid[g] <= 1'b0;
      end
    end
  end

  assign mic_in_ready  = lane_in_ready[0];
  assign dac_in_ready  = lane_in_ready[1];
  assign mic_out_valid = head_valid[0];
  assign dac_out_valid = head_valid[1];
  assign mic_out_data  = head_data[0];
  assign dac_out_data  = head_data[1];

endmodule

/* mic_hpf_and_compressor_curve_tb_top.sv */
// self-checking bench for the mic filter and compressor block
module mic_hpf_and_compressor_curve_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 24;
  localparam logic [9:0] A_MIC =
    {codec_filters_pkg::IDX_MIC_FILTER_CONFIG, 2'b00};
  localparam logic [9:0] A_CTL =
    {codec_filters_pkg::IDX_COMPRESSOR_CONTROL_A, 2'b00};
  localparam logic [9:0] A_SLP =
    {codec_filters_pkg::IDX_COMPRESSOR_SLOPES, 2'b00};
  localparam logic [9:0] A_KNEE =
    {codec_filters_pkg::IDX_COMPRESSOR_KNEE, 2'b00};
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [9:0]          paddr = '0;
  logic [31:0]         pwdata = '0;
  logic [3:0]          pstrb = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                mi_v, mi_r, mo_v, mo_r, di_v, di_r, do_v, do_r;
  logic signed [W-1:0] mi_d, mo_d, di_d, do_d, o1, o2, prev;
  logic [31:0]         r;
  logic                e;
  bit                  b;
  int                  n_mismatch = 0;
  int                  total_checks = 0;

  always #25 pclk = ~pclk;

  mic_hpf_and_compressor_curve #(.SAMPLE_W(W), .ADDR_W(10)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr,
    .mic_in_valid(mi_v), .mic_in_data(mi_d), .mic_in_ready(mi_r),
    .mic_out_valid(mo_v), .mic_out_data(mo_d), .mic_out_ready(mo_r),
    .dac_in_valid(di_v), .dac_in_data(di_d), .dac_in_ready(di_r),
    .dac_out_valid(do_v), .dac_out_data(do_d), .dac_out_ready(do_r));
  audio_lane_model #(.W(W)) u_mic (.pclk, .in_valid(mi_v),
    .in_data(mi_d), .in_ready(mi_r), .out_valid(mo_v),
    .out_data(mo_d), .out_ready(mo_r));
  audio_lane_model #(.W(W)) u_dac (.pclk, .in_valid(di_v),
    .in_data(di_d), .in_ready(di_r), .out_valid(do_v),
    .out_data(do_d), .out_ready(do_r));

  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ok(input bit c);
    total_checks++;
    if (!c)
    begin
      n_mismatch++;
      $display("ERROR %0t unexpected result", $time);
    end
  endtask
  // ========
  // bus master
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    bit done;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
      done = pready === 1'b1;
    end
    while (!done && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ok(done);
    if (!done)
      end_sim();
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'h0);
    ok(r === x && e === 1'b0);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask
  task automatic xfer(input bit dac, input logic signed [W-1:0] v,
                      output logic signed [W-1:0] o);
    int n;
    bit k;
    n = 0;
    if (dac)
      u_dac.send(v, k);
    else
      u_mic.send(v, k);
    while ((dac ? u_dac.got.size() : u_mic.got.size()) == 0 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    ok(k && n < 20);
    if (!k || n == 20)
      end_sim();
    else
      o = dac ? u_dac.got.pop_front() : u_mic.got.pop_front();
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("ERROR %0t run too long", $time);
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_MIC, 32'h10);
    rd(A_CTL, 32'h0);
    rd(A_SLP, 32'h0);
    rd(A_KNEE, 32'h0);
    apb(1'b0, 10'h9c, 32'h0, 4'h0);
    ok(e === 1'b1);
    apb(1'b1, A_CTL, 32'hc000, 4'h0);
    rd(A_CTL, 32'h0);
    wr(A_MIC, 32'h0);
    xfer(0, 24'sh123456, o1);
    ok(o1 === 24'sh123456);
    xfer(1, -24'sh054321, o1);
    ok(o1 === -24'sh054321);
    // higher cut-off codes must strip more of a dc step
    prev = 24'sh400000;
    for (int c = 0; c < 4; c++)
    begin
      // history only clears on a sample taken while bypassed
      wr(A_MIC, 32'h0);
      xfer(0, 24'sh000000, o1);
      ok(o1 === 24'sh000000);
      wr(A_MIC, 32'(32'h10 | (c << 5)));
      xfer(0, 24'sh100000, o1);
      ok(o1 === 24'sh100000);
      xfer(0, 24'sh100000, o2);
      ok(o2 < prev && o2 > 0);
      if (c == 0)
        ok(o2 > 24'sh0f0000);
      prev = o2;
    end
    wr(A_MIC, 32'h0);
    wr(A_KNEE, 32'h0780);
    wr(A_SLP, 32'h0028);
    rd(A_KNEE, 32'h0780);
    rd(A_SLP, 32'h0028);
    for (int p = 0; p < 2; p++)
    begin
      wr(A_CTL, p ? 32'hc000 : 32'h8000);
      xfer(p[0], 24'sh010000, o1);
      xfer(p[0], 24'sh040000, o2);
      ok(o1 > 24'sh040000 && o1 - o2 < (o1 >>> 3)
         && o2 - o1 < (o1 >>> 3));
      xfer(!p[0], 24'sh010000, o2);
      ok(o2 === 24'sh010000);
    end
    xfer(1, 24'sh000100, o1);
    ok(o1 > 24'sh009600 && o1 < 24'sh00d200);
    wr(A_CTL, 32'h4000);
    xfer(1, 24'sh010000, o1);
    ok(o1 === 24'sh010000);
    // stalled sinks: two words held, third refused; dac holds one
    @(negedge pclk);
    u_mic.stall = 1'b1;
    u_dac.stall = 1'b1;
    repeat (2) @(posedge pclk);
    u_mic.send(24'sh000111, b);
    u_mic.send(24'sh000222, b);
    u_dac.send(24'sh000333, b);
    @(negedge pclk);
    ok(mi_r === 1'b0 && di_r === 1'b1);
    u_mic.stall = 1'b0;
    u_dac.stall = 1'b0;
    repeat (4) @(posedge pclk);
    ok(u_mic.got.size() == 2 && u_dac.got.size() == 1);
    ok(u_mic.got[0] === 24'sh000111 && u_dac.got[0] === 24'sh000333
       && u_mic.got[1] === 24'sh000222);
    end_sim();
  end
endmodule
